// file: lcoc_top.sv
// What this block does
// - Field interruption switches both outputs off
// - Check feedback loop closed before re-enabling
// - Automatic mode restarts once clear, loop closed
// - Open feedback loop holds outputs off
// - Manual mode needs press then release
// - Restart ignored in lockout or interrupted field
// - Aux output mirrors inverted, or shows muting
// - Muting starts only on successive sensors
// - Muting ends when either sensor frees
// - Manual override after bad muting sequence
// - Muting lamp output shows muting state
// - Blanking one or two, never bottom beam
// - Two-beam blanking tolerates any two upper beams
// - Three beams one blanked, four beams two
// - Auxiliary device drives two opposite inputs
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
module lcoc_top
   import lcoc_pkg::*;
#(
   parameter int BEAMS   = LCOC_BEAMS,     // Beams in the curtain
   parameter int OVR_CYC = LCOC_OVR_CYC    // Override length in cycles
)
(
   input  wire logic             I_CLK,         // System clock
   input  wire logic             I_RST,         // Async reset, high
   input  wire logic [BEAMS-1:0] I_BEAM_BLOCKED, // Beam interrupted, bit 0 low
   input  wire logic             I_LOCKOUT,     // Internal fault or crosstalk
   input  wire logic             I_FEEDBACK,    // Contactor loop closed
   input  wire logic             I_RESTART,     // Restart button pressed
   input  wire logic             I_MUTE_A,      // Muting input A
   input  wire logic             I_MUTE_B,      // Muting input B
   input  wire logic             I_OVR_KEY,     // Override hold-to-run key
   input  wire logic             I_AUX_SAFE,    // Aux device, high = safe
   input  wire logic             I_AUX_SAFE_N,  // Aux device, low = safe
   input  wire logic             I_WB_CYC,      // Wishbone cycle
   input  wire logic             I_WB_STB,      // Wishbone strobe
   input  wire logic             I_WB_WE,       // Wishbone write
   input  wire logic [7:0]       I_WB_ADR,      // Wishbone byte address
   input  wire logic [3:0]       I_WB_SEL,      // Wishbone byte lanes
   input  wire logic [31:0]      I_WB_DAT,      // Wishbone write data
   output logic      [31:0]      O_WB_DAT,      // Wishbone read data
   output logic                  O_WB_ACK,      // Wishbone acknowledge
   output logic                  O_SAFE_OUT_1,  // Safety output one
   output logic                  O_SAFE_OUT_2,  // Safety output two
   output logic                  O_AUX_OUT,     // Non-safety signal output
   output logic                  O_MUTE_LAMP    // Muting lamp drive
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Count set bits of a beam vector
   function automatic logic [7:0] popcnt(input logic [BEAMS-1:0] v);
      logic [7:0] n;
      n = 8'h00;
      for (int i = 0; i < BEAMS; i++)
         n = n + {7'h00, v[i]};
      return n;
   endfunction

   // Blanking allowance clipped by the beam count
   function automatic logic [1:0] blank_limit(input logic [1:0] req);
      logic [1:0] lim;
      lim = req;
      if (BEAMS <= 2)
         lim = 2'h0;
      else if (BEAMS == 3 && req > 2'h1)
         lim = 2'h1;
      else if (req > 2'h2)
         lim = 2'h2;
      return lim;
   endfunction

   // ----------------------------------------------------------------
   // Registers and state
   // ----------------------------------------------------------------
   logic [5:0]     ctrl_q,   ctrl_d;     // Control register
   logic [31:0]    rdat_q,   rdat_d;     // Read data
   logic           ack_q,    ack_d;      // Bus acknowledge
   logic           unlock_q, unlock_d;   // Lockout clear pulse
   logic           lock_q,   lock_d;     // Latched lockout
   lcoc_state_type st_q,     st_d;       // Output state
   logic           out_q,    out_d;      // Outputs on
   logic           aux_q,    aux_d;      // Aux output
   logic           lamp_q,   lamp_d;     // Lamp output
   logic           ovr_q,    ovr_d;      // Override running
   logic           ovr_req_q, ovr_req_d; // Override armed by software
   logic [31:0]    ovr_cnt_q, ovr_cnt_d; // Override time left
   logic           muting;               // From tracker
   logic           mute_err;             // From tracker
   logic           field_clear;          // Field free after blanking
   logic           aux_ok;               // Auxiliary device safe
   logic           trip;                 // Any reason to be off
   logic           bus_req;              // Fresh bus request

   lcoc_mute u_mute
   (
      .I_CLK    (I_CLK),
      .I_RST    (I_RST),
      .i_enable (ctrl_q[LCOC_CTRL_MUTEN_BIT]),
      .i_mute_a (I_MUTE_A),
      .i_mute_b (I_MUTE_B),
      .o_muting (muting),
      .o_error  (mute_err)
   );

   // ----------------------------------------------------------------
   // Trip conditions
   // ----------------------------------------------------------------
   always_comb
   begin
      // Bottom beam is sync: never blanked
      // Any one or two upper beams, adjacent or not
      field_clear = !I_BEAM_BLOCKED[0] &&
                    (popcnt(I_BEAM_BLOCKED) <=
                     {6'h00, blank_limit(ctrl_q[LCOC_CTRL_BLANK_LSB +: 2])});
      // Opposite polarity pair; disagreement counts as unsafe
      aux_ok = I_AUX_SAFE && !I_AUX_SAFE_N;
      // Muting or override masks the field only, never the aux device
      trip = (!field_clear && !muting && !ovr_q) || !aux_ok || lock_q;
   end

   // ----------------------------------------------------------------
   // Output state machine
   // ----------------------------------------------------------------
   always_comb
   begin
      logic fb_ok;
      fb_ok = I_FEEDBACK || !ctrl_q[LCOC_CTRL_FBEN_BIT];
      st_d  = st_q;
      unique case (st_q)
         LCOC_ST_ON:
            if (trip)
               st_d = LCOC_ST_OFF;
         LCOC_ST_OFF:
            // Loop must be closed to leave
            if (!trip && fb_ok)
               st_d = ctrl_q[LCOC_CTRL_MANUAL_BIT] ?
                      LCOC_ST_WAIT_PRESS : LCOC_ST_ON;
         LCOC_ST_WAIT_PRESS:
            if (trip || !fb_ok)
               st_d = LCOC_ST_OFF;
            else if (I_RESTART)
               st_d = LCOC_ST_WAIT_REL;
         LCOC_ST_WAIT_REL:
            if (trip || !fb_ok)
               st_d = LCOC_ST_OFF;
            else if (!I_RESTART)
               st_d = LCOC_ST_ON;
      endcase
      // Switch-off on the next clock edge after the trip is seen: out_d follows st_d, not st_q
      out_d  = (st_d == LCOC_ST_ON);
      lock_d = (lock_q || I_LOCKOUT) && !(unlock_q && !I_LOCKOUT);
      // Aux: inverted mirror or muting/diagnostic
      aux_d  = ctrl_q[LCOC_CTRL_AUXMD_BIT] ?
               (muting || ovr_q || lock_q || mute_err) : !out_d;
      lamp_d = muting || ovr_q;
   end

   // ----------------------------------------------------------------
   // Override timer
   // ----------------------------------------------------------------
   always_comb
   begin
      ovr_d     = ovr_q;
      ovr_cnt_d = ovr_cnt_q;
      ovr_req_d = ovr_req_q;
      if (ovr_q)
      begin
         // Held-to-run, time limited so it cannot stay forever
         if (!I_OVR_KEY || ovr_cnt_q == 32'h0000_0000 || !aux_ok)
            ovr_d = 1'b0;
         else
            ovr_cnt_d = ovr_cnt_q - 32'h0000_0001;
      end
      else if (ovr_req_q && mute_err && I_OVR_KEY && !lock_q)
      begin
         ovr_d     = 1'b1;
         ovr_req_d = 1'b0;
         ovr_cnt_d = 32'(OVR_CYC);
      end
      if (bus_req && I_WB_WE && I_WB_ADR == LCOC_CMD_ADDR && I_WB_SEL[0]
          && I_WB_DAT[LCOC_CMD_OVR_BIT])
         ovr_req_d = 1'b1;
      if (!mute_err)
         ovr_req_d = 1'b0;
   end

   // ----------------------------------------------------------------
   // Wishbone slave, one wait state then ack
   // ----------------------------------------------------------------
   always_comb
   begin
      bus_req  = I_WB_CYC && I_WB_STB && !ack_q;
      ack_d    = bus_req;
      ctrl_d   = ctrl_q;
      rdat_d   = 32'h0000_0000;
      unlock_d = 1'b0;
      if (bus_req && I_WB_WE)
      begin
         if (I_WB_ADR == LCOC_CTRL_ADDR && I_WB_SEL[0])
            ctrl_d = I_WB_DAT[5:0];
         else if (I_WB_ADR == LCOC_CMD_ADDR && I_WB_SEL[0])
            unlock_d = I_WB_DAT[LCOC_CMD_UNLOCK_BIT];
      end
      else if (bus_req)
      begin
         if (I_WB_ADR == LCOC_CTRL_ADDR)
            rdat_d = {26'h000_0000, ctrl_q};
         else if (I_WB_ADR == LCOC_STATUS_ADDR)
         begin
            rdat_d[LCOC_ST_OUT_BIT]  = out_q;
            rdat_d[LCOC_ST_MUTE_BIT] = muting;
            rdat_d[LCOC_ST_OVR_BIT]  = ovr_q;
            rdat_d[LCOC_ST_LOCK_BIT] = lock_q;
            rdat_d[LCOC_ST_MERR_BIT] = mute_err;
            rdat_d[LCOC_ST_STATE_LSB +: 2] = st_q;
         end
      end
   end

   // Register everything
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         ctrl_q    <= LCOC_CTRL_RESET;
         rdat_q    <= 32'h0000_0000;
         ack_q     <= 1'b0;
         unlock_q  <= 1'b0;
         lock_q    <= 1'b0;
         st_q      <= LCOC_ST_OFF;
         out_q     <= 1'b0;
         aux_q     <= 1'b1;
         lamp_q    <= 1'b0;
         ovr_q     <= 1'b0;
         ovr_req_q <= 1'b0;
         ovr_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         rdat_q    <= rdat_d;
         ack_q     <= ack_d;
         unlock_q  <= unlock_d;
         lock_q    <= lock_d;
         st_q      <= st_d;
         out_q     <= out_d;
         aux_q     <= aux_d;
         lamp_q    <= lamp_d;
         ovr_q     <= ovr_d;
         ovr_req_q <= ovr_req_d;
         ovr_cnt_q <= ovr_cnt_d;
      end
   end

   // Outputs straight from flip-flops
   assign O_SAFE_OUT_1 = out_q;
   assign O_SAFE_OUT_2 = out_q;
   assign O_AUX_OUT    = aux_q;
   assign O_MUTE_LAMP  = lamp_q;
   assign O_WB_DAT     = rdat_q;
   assign O_WB_ACK     = ack_q;

endmodule

// file: lcoc_pkg.sv
package lcoc_pkg;

   // ----------------------------------------------------------------
   // Wishbone register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] LCOC_CTRL_ADDR   = 8'h00;    // Mode control
   localparam logic [7:0] LCOC_STATUS_ADDR = 8'h04;    // Live state
   localparam logic [7:0] LCOC_CMD_ADDR    = 8'h08;    // Command strobes

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int LCOC_CTRL_MANUAL_BIT = 0;            // Manual restart mode
   localparam int LCOC_CTRL_AUXMD_BIT  = 1;            // Aux shows muting/diag
   localparam int LCOC_CTRL_BLANK_LSB  = 2;            // Blanking count, 2 bits
   localparam int LCOC_CTRL_FBEN_BIT   = 4;            // Feedback monitor on
   localparam int LCOC_CTRL_MUTEN_BIT  = 5;            // Muting enabled
   localparam logic [5:0] LCOC_CTRL_RESET = 6'h31;     // Manual, fb, muting

   // ----------------------------------------------------------------
   // Command register fields
   // ----------------------------------------------------------------
   localparam int LCOC_CMD_OVR_BIT     = 0;            // Start override
   localparam int LCOC_CMD_UNLOCK_BIT  = 1;            // Clear lockout

   // ----------------------------------------------------------------
   // Status register fields
   // ----------------------------------------------------------------
   localparam int LCOC_ST_OUT_BIT      = 0;            // Outputs on
   localparam int LCOC_ST_MUTE_BIT     = 1;            // Muting active
   localparam int LCOC_ST_OVR_BIT      = 2;            // Override active
   localparam int LCOC_ST_LOCK_BIT     = 3;            // Lockout
   localparam int LCOC_ST_MERR_BIT     = 4;            // Bad muting sequence
   localparam int LCOC_ST_STATE_LSB    = 5;            // Main state, 2 bits

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int LCOC_CLK_MHZ         = 100;          // System clock
   localparam int LCOC_OVR_MS          = 60;           // Override time limit
   localparam int LCOC_OVR_CYC         = LCOC_OVR_MS * 1000 * LCOC_CLK_MHZ;
   localparam int LCOC_BEAMS           = 4;            // Beams in curtain

   // Main output states
   typedef enum logic [1:0]
   {
      LCOC_ST_OFF,
      LCOC_ST_WAIT_PRESS,
      LCOC_ST_WAIT_REL,
      LCOC_ST_ON
   } lcoc_state_type;

endpackage

// file: lcoc_mute.sv
`timescale 1ns/1ns
// Muting sequence tracker: ordered activation of two sensor inputs
module lcoc_mute
   import lcoc_pkg::*;
(
   input  wire logic I_CLK,         // System clock
   input  wire logic I_RST,         // Async reset, high
   input  wire logic i_enable,      // Muting allowed
   input  wire logic i_mute_a,      // Sensor input A
   input  wire logic i_mute_b,      // Sensor input B
   output logic      o_muting,      // Muting sequence running
   output logic      o_error        // Both sensors rose together
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic       prev_a_q, prev_a_d;  // Last sample of A
   logic       prev_b_q, prev_b_d;  // Last sample of B
   logic       first_q,  first_d;   // One sensor is active alone
   logic       mute_q,   mute_d;    // Muting running
   logic       err_q,    err_d;     // Bad sequence seen

   // Next state of the sequence tracker
   always_comb
   begin
      prev_a_d = i_mute_a;
      prev_b_d = i_mute_b;
      first_d  = first_q;
      mute_d   = mute_q;
      err_d    = err_q;
      if (!i_enable)
      begin
         first_d = 1'b0;
         mute_d  = 1'b0;
      end
      else if (mute_q)
      begin
         // Either sensor going free ends muting
         if (!i_mute_a || !i_mute_b)
         begin
            mute_d  = 1'b0;
            first_d = 1'b0;
         end
      end
      else if (i_mute_a && i_mute_b)
      begin
         // Second sensor after the first: valid sequence
         if (first_q)
         begin
            mute_d = 1'b1;
            err_d  = 1'b0;
         end
         // Simultaneous rise could be a person: refuse
         else if (!prev_a_q && !prev_b_q)
            err_d = 1'b1;
      end
      else
         first_d = i_mute_a ^ i_mute_b;
   end

   // Register the tracker
   always_ff @(posedge I_CLK or posedge I_RST)
   begin
      if (I_RST)
      begin
         prev_a_q <= 1'b0;
         prev_b_q <= 1'b0;
         first_q  <= 1'b0;
         mute_q   <= 1'b0;
         err_q    <= 1'b0;
      end
      else
      begin
         prev_a_q <= prev_a_d;
         prev_b_q <= prev_b_d;
         first_q  <= first_d;
         mute_q   <= mute_d;
         err_q    <= err_d;
      end
   end

   assign o_muting = mute_q;
   assign o_error  = err_q;

endmodule

// file: lcoc_chk_sva.sv
`timescale 1ns/1ns
module lcoc_chk
   import lcoc_pkg::*;
#(
   parameter int BEAMS   = LCOC_BEAMS,   // Beams in curtain
   parameter int OVR_CYC = LCOC_OVR_CYC  // Override length
)
(
   input wire logic             I_CLK,          // Clock
   input wire logic             I_RST,          // Async reset
   input wire logic [BEAMS-1:0] I_BEAM_BLOCKED, // Beam states
   input wire logic             I_LOCKOUT,      // Fault input
   input wire logic             I_FEEDBACK,     // Loop closed
   input wire logic             I_MUTE_A,       // Sensor A
   input wire logic             I_MUTE_B,       // Sensor B
   input wire logic             I_OVR_KEY,      // Override key
   input wire logic             I_AUX_SAFE,     // Aux, high safe
   input wire logic             I_AUX_SAFE_N,   // Aux, low safe
   input wire logic             O_SAFE_OUT_1,   // Output one
   input wire logic             O_SAFE_OUT_2,   // Output two
   input wire logic             O_MUTE_LAMP     // Lamp drive
);
   // ------
   // Common clock and reset
   // ------
   default clocking cb @(posedge I_CLK);
   endclocking
   default disable iff (I_RST);

   // Bottom beam hit that nothing may mask
   sequence s_bottom_hit;
      I_BEAM_BLOCKED[0] && !(I_MUTE_A && I_MUTE_B) && !I_OVR_KEY;
   endsequence
   // Sensors leave muting, no key held
   sequence s_mute_gone;
      !(I_MUTE_A && I_MUTE_B) && !I_OVR_KEY;
   endsequence
   // Both sensors rise in the same cycle from idle
   sequence s_both_rise;
      $rose(I_MUTE_A) && $rose(I_MUTE_B) && !O_MUTE_LAMP && !I_OVR_KEY;
   endsequence

   AST_PAIR: assert property (O_SAFE_OUT_1 == O_SAFE_OUT_2)
      else $error("Safety outputs differ");
   // Three cycles allow the muting state to drain first
   AST_TRIP: assert property (s_bottom_hit [*3] |=> !O_SAFE_OUT_1)
      else $error("Bottom beam did not trip outputs");
   AST_FB_OPEN: assert property (!I_FEEDBACK && !O_SAFE_OUT_1 |=> !O_SAFE_OUT_1)
      else $error("Restart with feedback loop open");
   AST_AUX: assert property (!(I_AUX_SAFE && !I_AUX_SAFE_N) |=> !O_SAFE_OUT_1)
      else $error("Aux device fault did not trip");
   // Lockout is latched first, so the trip lands one cycle later
   AST_LOCK: assert property (I_LOCKOUT |=> ##1 !O_SAFE_OUT_1 [*2])
      else $error("Outputs on during lockout");
   AST_RISE: assert property ($rose(O_SAFE_OUT_1) |-> $past(I_FEEDBACK) && !$past(I_BEAM_BLOCKED[0]))
      else $error("Outputs rose without clear field and loop");
   AST_MUTE_END: assert property (s_mute_gone [*3] |=> !O_MUTE_LAMP)
      else $error("Muting lamp stayed on");
   AST_SIMUL: assert property (s_both_rise |=> !O_MUTE_LAMP [*2])
      else $error("Muting began on simultaneous sensors");
endmodule

bind lcoc_top lcoc_chk #(.BEAMS(BEAMS), .OVR_CYC(OVR_CYC)) u_lcoc_chk (
   .I_CLK(I_CLK), .I_RST(I_RST), .I_BEAM_BLOCKED(I_BEAM_BLOCKED),
   .I_LOCKOUT(I_LOCKOUT), .I_FEEDBACK(I_FEEDBACK), .I_MUTE_A(I_MUTE_A),
   .I_MUTE_B(I_MUTE_B), .I_OVR_KEY(I_OVR_KEY), .I_AUX_SAFE(I_AUX_SAFE),
   .I_AUX_SAFE_N(I_AUX_SAFE_N), .O_SAFE_OUT_1(O_SAFE_OUT_1),
   .O_SAFE_OUT_2(O_SAFE_OUT_2), .O_MUTE_LAMP(O_MUTE_LAMP));

// file: lcoc_field.sv
`timescale 1ns/1ns
// Far side: contactors, sensors, button, aux device
module lcoc_field
(
   input  wire logic       I_CLK,        // System clock
   input  wire logic       I_RST,        // Async reset, high
   input  wire logic       i_out,        // Safety output drive
   input  wire logic       i_fb_fault,   // Stuck contact, loop open
   input  wire logic       i_press,      // Operator presses
   input  wire logic [3:0] i_sens,       // Four muting sensors
   input  wire logic [1:0] i_aux_bad,    // 1 unsafe, 2 disagree
   output logic            o_feedback,   // Feedback loop closed
   output logic            o_restart,    // Restart contact
   output logic            o_mute_a,     // Muting input A
   output logic            o_mute_b,     // Muting input B
   output logic            o_aux_safe,   // Aux channel, high safe
   output logic            o_aux_safe_n  // Aux channel, low safe
);
   logic [1:0] coil_q;                   // Contactor drop delay line
   logic [1:0] coil_d;                   // Next delay line

   // Contactors lag the outputs by two cycles, as real coils do
   always_comb coil_d = {coil_q[0], i_out};
   always_ff @(posedge I_CLK or posedge I_RST)
      if (I_RST)
         coil_q <= 2'b00;
      else
         coil_q <= coil_d;

   // Loop closes only once the contactor has really dropped
   assign o_feedback   = !coil_q[1] && !i_fb_fault;
   assign o_restart    = i_press;
   assign o_mute_a     = i_sens[0] | i_sens[1];
   assign o_mute_b     = i_sens[2] | i_sens[3];
   assign o_aux_safe   = !i_aux_bad[0];
   assign o_aux_safe_n = |i_aux_bad;
endmodule

// file: lcoc_top_tb.sv
`timescale 1ns/1ns
module lcoc_top_tb;
   import lcoc_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, lock = 1'b0, key = 1'b0;
   logic       fault = 1'b0, press = 1'b0, req = 1'b0, we = 1'b0;
   logic [3:0] beam = 4'h0, sens = 4'h0;
   logic [1:0] aux_bad = 2'b00;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000, rdat, r;
   logic       ack, out1, out2, auxo, lamp, fb, rs, ma, mb, aux_s, aux_n;
   int         bad_count = 0, tests_run = 0;
   logic [3:0] pat [6] = '{4'hA, 4'h6, 4'hE, 4'h0, 4'h1, 4'h0};
   logic       expv [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

   always #5 clk = ~clk;

   lcoc_top #(.BEAMS(4), .OVR_CYC(20)) u_lcoc_top (.I_CLK(clk), .I_RST(rst),
      .I_BEAM_BLOCKED(beam), .I_LOCKOUT(lock), .I_FEEDBACK(fb),
      .I_RESTART(rs), .I_MUTE_A(ma), .I_MUTE_B(mb), .I_OVR_KEY(key),
      .I_AUX_SAFE(aux_s), .I_AUX_SAFE_N(aux_n), .I_WB_CYC(req),
      .I_WB_STB(req), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF),
      .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .O_SAFE_OUT_1(out1), .O_SAFE_OUT_2(out2), .O_AUX_OUT(auxo),
      .O_MUTE_LAMP(lamp));
   lcoc_field u_lcoc_field (.I_CLK(clk), .I_RST(rst), .i_out(out1),
      .i_fb_fault(fault), .i_press(press), .i_sens(sens),
      .i_aux_bad(aux_bad), .o_feedback(fb), .o_restart(rs),
      .o_mute_a(ma), .o_mute_b(mb), .o_aux_safe(aux_s),
      .o_aux_safe_n(aux_n));

   // ------
   // Helpers
   // ------
   task step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task outs(input logic e);
      chk({out1, out2}, e ? 32'h3 : 32'h0);
   endtask
   // Classic cycle; request held until ack is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      req <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1)
      begin
         bad_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, ack, 1'b1);
      end
      r = rdat;
      req <= 1'b0;
      we <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, e);
      wb(1'b0, a, 32'h0000_0000);
      chk(r & m, e);
   endtask
   // Press then release the button
   task press_rel;
      press <= 1'b1;
      step(2);
      press <= 1'b0;
      step(3);
   endtask
   task report_and_stop;
      $display("checks=%0d errors=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ------
   // Scenarios
   // ------
   initial
   begin
      step(4);
      rst <= 1'b0;
      step(2);
      rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0000_0031);
      rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000);
      outs(1'b0);
      press_rel;
      outs(1'b1);
      chk(auxo, 1'b0);
      beam <= 4'h4;
      step(3);
      outs(1'b0);
      chk(auxo, 1'b1);
      press_rel;
      outs(1'b0);
      beam <= 4'h0;
      step(5);
      outs(1'b0);
      lock <= 1'b1;
      step(1);
      lock <= 1'b0;
      step(2);
      press_rel;
      outs(1'b0);
      rd_chk(8'h04, 32'h8, 32'h8);
      wb(1'b1, 8'h08, 32'h0000_0002);
      press_rel;
      outs(1'b1);
      fault <= 1'b1;
      beam <= 4'h2;
      step(2);
      beam <= 4'h0;
      step(5);
      press_rel;
      outs(1'b0);
      fault <= 1'b0;
      step(2);
      press_rel;
      outs(1'b1);
      wb(1'b1, 8'h00, 32'h0000_003C);
      for (int i = 0; i < 6; i++)
      begin
         beam <= pat[i];
         step(6);
         outs(expv[i]);
      end
      for (int i = 1; i < 3; i++)
      begin
         aux_bad <= 2'(i);
         step(3);
         outs(1'b0);
         aux_bad <= 2'b00;
         step(6);
         outs(1'b1);
      end
      wb(1'b1, 8'h00, 32'h0000_0032);
      sens <= 4'h1;
      step(2);
      sens <= 4'h5;
      step(3);
      chk(lamp, 1'b1);
      chk(auxo, 1'b1);
      beam <= 4'h2;
      step(3);
      outs(1'b1);
      sens <= 4'h4;
      step(3);
      chk(lamp, 1'b0);
      outs(1'b0);
      beam <= 4'h0;
      sens <= 4'h0;
      step(6);
      sens <= 4'h5;
      step(3);
      chk(lamp, 1'b0);
      rd_chk(8'h04, 32'h10, 32'h10);
      sens <= 4'h0;
      wb(1'b1, 8'h08, 32'h0000_0001);
      key <= 1'b1;
      step(3);
      chk(lamp, 1'b1);
      step(25);
      chk(lamp, 1'b0);
      key <= 1'b0;
      step(2);
      report_and_stop;
   end

   // Whole run is under two thousand ns; far past that means a hang
   initial
   begin
      #100000;
      bad_count++;
      report_and_stop;
   end
endmodule
